// ==== include/adp_pkg.sv ====
package adp_pkg;
  localparam int unsigned SYS_CLK_KHZ   = 250000;
  localparam int unsigned SCL_KHZ       = 100;
  localparam int unsigned QTR_CYC       = SYS_CLK_KHZ / (SCL_KHZ * 4);
  localparam int unsigned DIAG_WAIT_US  = 1000;
  localparam int unsigned DIAG_WAIT_CYC = (DIAG_WAIT_US * SYS_CLK_KHZ + 999) / 1000;
  localparam int unsigned QTR_MIN       = 8;

  localparam logic [6:0] DEV_ADDR_DFLT = 7'h48;
  localparam logic [7:0] IB_RST        = 8'h00;
  localparam logic [3:0] BIT_ACK       = 4'h8;
  localparam logic [1:0] DB_LAST       = 2'h3;

  localparam int IB1_DIAG = 6;
  localparam int IB2_ON   = 4;
  localparam logic [7:0] OFFS_IB1_MASK = 8'h26;

  localparam int DB_HI    = 7;
  localparam int DB_MID   = 6;
  localparam int DB_CUR   = 5;
  localparam int DB_MODE  = 4;
  localparam int DB_SLOAD = 3;
  localparam int DB_LOAD  = 2;
  localparam int DB_SVCC  = 1;
  localparam int DB_SGND  = 0;

  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_IB1  = 4'h1;
  localparam logic [3:0] REG_IB2  = 4'h2;
  localparam logic [3:0] REG_STAT = 4'h3;
  localparam logic [3:0] REG_DB   = 4'h4;
  localparam int CTRL_WR = 0;
  localparam int CTRL_RD = 1;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_ADDR = 3'h1,
    S_AACK = 3'h3,
    S_WR   = 3'h2,
    S_WACK = 3'h6,
    S_RD   = 3'h7,
    S_RACK = 3'h5
  } adp_slv_e;

  typedef enum logic [2:0] {
    H_IDLE  = 3'h0,
    H_WAIT  = 3'h1,
    H_START = 3'h3,
    H_BIT   = 3'h2,
    H_STOP  = 3'h6
  } adp_mst_e;
endpackage : adp_pkg

// ==== include/adp_link_if.sv ====
`timescale 1ns/10ps
interface adp_link_if;
  logic scl_o;
  logic scl_oe;
  logic sda_h_o;
  logic sda_h_oe;
  logic sda_d_o;
  logic sda_d_oe;
  logic scl;
  logic sda;

  // Open-drain wired AND with pull-up
  assign scl = !(scl_oe && !scl_o);
  assign sda = !((sda_h_oe && !sda_h_o) || (sda_d_oe && !sda_d_o));

  modport host (output scl_o, scl_oe, sda_h_o, sda_h_oe, input scl, sda);
  modport dev (output sda_d_o, sda_d_oe, input scl, sda);
endinterface : adp_link_if

// ==== hw/adp_dev.sv ====
// Contract
// - Rear-right bit2 flags open load, turn-on
// - Rear-right bit2 flags offset, permanent diagnosis
// - Rear-right bit1 flags short to supply
// - Rear-right bit0 flags short to ground
// - Diag start: address write, first order bit6
// - Status read returns four bytes, host acks
// - Host waits 1 ms before status read
// - Amp on: orders X0000000, XXX1XX11
// - Amp off: second order bit4 cleared
// - Offset enable: orders XX1XX11X, XXX1XXXX
// - Read stops offset detection; bit2 valid
// - Host waits 1 ms before stopping read
// - Offset detection flags about 2 V DC
// - Bit4 zero turn-on, one permanent
// - Bit3 flags shorted load
//
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/10ps
module adp_dev #(
  parameter logic [6:0] DEV_ADDR = adp_pkg::DEV_ADDR_DFLT
) (
  input  wire logic       SYS_CLK,
  input  wire logic       RESET,
  adp_link_if.dev         LINK,
  input  wire logic [3:0] OPEN_LOAD,
  input  wire logic [3:0] OFFSET_DET,
  input  wire logic [3:0] SHORT_VCC,
  input  wire logic [3:0] SHORT_GND,
  input  wire logic [3:0] SHORT_LOAD,
  input  wire logic [3:0] CUR_OPEN,
  input  wire logic       TURNON_DONE,
  input  wire logic       THERM_WARN2,
  input  wire logic       THERM_WARN3,
  input  wire logic       SSR_MUTE,
  output logic      [7:0] FIRST_IB,
  output logic      [7:0] SECOND_IB,
  output logic            AMP_ON,
  output logic            DIAG_EN,
  output logic            OFFSET_EN,
  output logic            DIAG_PERM
);
  if (DEV_ADDR[6:3] == 4'h0 || DEV_ADDR[6:3] == 4'hf) begin : g_bad_addr
    $error("Reserved bus address");
  end

  logic             scl_m_q;
  logic             scl_q;
  logic             scl_p_q;
  logic             sda_m_q;
  logic             sda_q;
  logic             sda_p_q;
  adp_pkg::adp_slv_e st_q, st_d;
  logic [3:0]       cnt_q, cnt_d;
  logic [7:0]       sh_q, sh_d;
  logic [1:0]       idx_q, idx_d;
  logic             rw_q, rw_d;
  logic             drv_q, drv_d;
  logic             ack_q, ack_d;
  logic [7:0]       ib1_q, ib1_d;
  logic [7:0]       ib2_q, ib2_d;
  logic             perm_q, perm_d;
  logic             offen_q, offen_d;
  logic [3:0]       open_q, open_d;
  logic [3:0]       offs_q, offs_d;
  logic [3:0]       svcc_q, svcc_d;
  logic [3:0]       sgnd_q, sgnd_d;
  logic [3:0]       sload_q, sload_d;
  logic             clr;
  logic [7:0]       tx;
  logic             rise;
  logic             fall;
  logic             start;
  logic             stop;

  // The second and third stages of each synchroniser feed the edge logic
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      scl_m_q <= 1'b1;
      scl_q   <= 1'b1;
      scl_p_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_q   <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_m_q <= LINK.scl;
      scl_q   <= scl_m_q;
      scl_p_q <= scl_q;
      sda_m_q <= LINK.sda;
      sda_q   <= sda_m_q;
      sda_p_q <= sda_q;
    end
  end

  assign rise  = scl_q && !scl_p_q;
  assign fall  = !scl_q && scl_p_q;
  assign start = scl_q && scl_p_q && sda_p_q && !sda_q;
  assign stop  = scl_q && scl_p_q && !sda_p_q && sda_q;

  function automatic logic [7:0] diag_byte(input logic [1:0] ch);
    logic [7:0] b;
    b = 8'h00;
    b[adp_pkg::DB_CUR]   = CUR_OPEN[ch];
    b[adp_pkg::DB_MODE]  = perm_q;
    b[adp_pkg::DB_SLOAD] = sload_q[ch];
    // Offset result replaces open load once permanent or offset-test mode
    b[adp_pkg::DB_LOAD]  = (perm_q || offen_q) ? offs_q[ch] : open_q[ch];
    b[adp_pkg::DB_SVCC]  = svcc_q[ch];
    b[adp_pkg::DB_SGND]  = sgnd_q[ch];
    case (ch)
      2'h1: begin
        b[adp_pkg::DB_HI]  = offen_q;
        b[adp_pkg::DB_MID] = SSR_MUTE;
      end
      2'h2: begin
        b[adp_pkg::DB_HI]  = ib2_q[adp_pkg::IB2_ON];
        b[adp_pkg::DB_MID] = ib1_q[adp_pkg::IB1_DIAG];
      end
      2'h3: begin
        b[adp_pkg::DB_HI]  = THERM_WARN2;
        b[adp_pkg::DB_MID] = THERM_WARN3;
      end
      default: begin
      end
    endcase
    return b;
  endfunction : diag_byte

  always_comb begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    sh_d    = sh_q;
    idx_d   = idx_q;
    rw_d    = rw_q;
    drv_d   = drv_q;
    ack_d   = ack_q;
    ib1_d   = ib1_q;
    ib2_d   = ib2_q;
    offen_d = offen_q;
    clr     = 1'b0;
    tx      = diag_byte(idx_q + 2'h1);
    if (stop) begin
      st_d  = adp_pkg::S_IDLE;
      drv_d = 1'b0;
    end else if (start) begin
      st_d  = adp_pkg::S_ADDR;
      cnt_d = 4'h0;
      idx_d = 2'h0;
      drv_d = 1'b0;
    end else begin
      case (st_q)
        adp_pkg::S_ADDR, adp_pkg::S_WR: begin
          if (rise) begin
            sh_d  = {sh_q[6:0], sda_q};
            cnt_d = cnt_q + 4'h1;
          end else if (fall && cnt_q == adp_pkg::BIT_ACK) begin
            drv_d = 1'b1;
            if (st_q == adp_pkg::S_ADDR) begin
              if (sh_q[7:1] == DEV_ADDR) begin
                st_d = adp_pkg::S_AACK;
                rw_d = sh_q[0];
              end else begin
                st_d  = adp_pkg::S_IDLE;
                drv_d = 1'b0;
              end
            end else begin
              st_d = adp_pkg::S_WACK;
              // Bytes beyond the second are acked and dropped
              if (idx_q == 2'h0) begin
                ib1_d = sh_q;
                clr   = sh_q[adp_pkg::IB1_DIAG];
                idx_d = 2'h1;
              end else if (idx_q == 2'h1) begin
                ib2_d   = sh_q;
                offen_d = ((ib1_q & adp_pkg::OFFS_IB1_MASK) == adp_pkg::OFFS_IB1_MASK)
                          && sh_q[adp_pkg::IB2_ON];
                idx_d   = 2'h2;
              end
            end
          end
        end
        adp_pkg::S_AACK: begin
          if (fall) begin
            cnt_d = 4'h0;
            if (rw_q) begin
              st_d  = adp_pkg::S_RD;
              sh_d  = diag_byte(2'h0);
              drv_d = !sh_d[7];
            end else begin
              st_d  = adp_pkg::S_WR;
              drv_d = 1'b0;
            end
          end
        end
        adp_pkg::S_WACK: begin
          if (fall) begin
            st_d  = adp_pkg::S_WR;
            cnt_d = 4'h0;
            drv_d = 1'b0;
          end
        end
        adp_pkg::S_RD: begin
          if (fall) begin
            cnt_d = cnt_q + 4'h1;
            if (cnt_q == adp_pkg::BIT_ACK - 4'h1) begin
              st_d  = adp_pkg::S_RACK;
              drv_d = 1'b0;
            end else begin
              sh_d  = {sh_q[6:0], 1'b0};
              drv_d = !sh_q[6];
            end
          end
        end
        adp_pkg::S_RACK: begin
          if (rise) begin
            ack_d = !sda_q;
          end else if (fall) begin
            if (idx_q == adp_pkg::DB_LAST) begin
              // Full status read ends the offset test and releases held flags
              st_d    = adp_pkg::S_IDLE;
              clr     = 1'b1;
              offen_d = 1'b0;
            end else if (ack_q) begin
              st_d  = adp_pkg::S_RD;
              idx_d = idx_q + 2'h1;
              cnt_d = 4'h0;
              sh_d  = tx;
              drv_d = !tx[7];
            end else begin
              st_d = adp_pkg::S_IDLE;
            end
          end
        end
        default: begin
          drv_d = 1'b0;
        end
      endcase
    end
    // Sticky flags, a new event wins over a clear in the same cycle
    open_d  = (open_q & {4{!clr}}) | OPEN_LOAD;
    offs_d  = (offs_q & {4{!clr}}) | OFFSET_DET;
    svcc_d  = (svcc_q & {4{!clr}}) | SHORT_VCC;
    sgnd_d  = (sgnd_q & {4{!clr}}) | SHORT_GND;
    sload_d = (sload_q & {4{!clr}}) | SHORT_LOAD;
    perm_d  = TURNON_DONE || (perm_q && !(clr && st_q == adp_pkg::S_WR));
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      st_q    <= adp_pkg::S_IDLE;
      cnt_q   <= 4'h0;
      sh_q    <= 8'h00;
      idx_q   <= 2'h0;
      rw_q    <= 1'b0;
      drv_q   <= 1'b0;
      ack_q   <= 1'b0;
      ib1_q   <= adp_pkg::IB_RST;
      ib2_q   <= adp_pkg::IB_RST;
      perm_q  <= 1'b0;
      offen_q <= 1'b0;
      open_q  <= 4'h0;
      offs_q  <= 4'h0;
      svcc_q  <= 4'h0;
      sgnd_q  <= 4'h0;
      sload_q <= 4'h0;
    end else begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      sh_q    <= sh_d;
      idx_q   <= idx_d;
      rw_q    <= rw_d;
      drv_q   <= drv_d;
      ack_q   <= ack_d;
      ib1_q   <= ib1_d;
      ib2_q   <= ib2_d;
      perm_q  <= perm_d;
      offen_q <= offen_d;
      open_q  <= open_d;
      offs_q  <= offs_d;
      svcc_q  <= svcc_d;
      sgnd_q  <= sgnd_d;
      sload_q <= sload_d;
    end
  end

  assign LINK.sda_d_o  = 1'b0;
  assign LINK.sda_d_oe = drv_q;
  assign FIRST_IB      = ib1_q;
  assign SECOND_IB     = ib2_q;
  assign AMP_ON        = ib2_q[adp_pkg::IB2_ON];
  assign DIAG_EN       = ib1_q[adp_pkg::IB1_DIAG];
  assign OFFSET_EN     = offen_q;
  assign DIAG_PERM     = perm_q;
endmodule : adp_dev

// ==== hw/adp_host.sv ====
`timescale 1ns/10ps
module adp_host #(
  parameter int unsigned QTR      = adp_pkg::QTR_CYC,
  parameter int unsigned WAIT_CYC = adp_pkg::DIAG_WAIT_CYC,
  parameter logic [6:0]  DEV_ADDR = adp_pkg::DEV_ADDR_DFLT
) (
  input  wire logic       SYS_CLK,
  input  wire logic       RESET,
  adp_link_if.host        LINK,
  input  wire logic [3:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA
);
  if (QTR < adp_pkg::QTR_MIN || WAIT_CYC < 1) begin : g_bad_par
    $error("QTR or WAIT_CYC too small");
  end

  localparam int QW = $clog2(QTR);

  logic              sda_m_q;
  logic              sda_q;
  adp_pkg::adp_mst_e st_q, st_d;
  logic [QW-1:0]     qc_q, qc_d;
  logic [1:0]        ph_q, ph_d;
  logic [3:0]        bit_q, bit_d;
  logic [2:0]        byte_q, byte_d;
  logic [7:0]        sh_q, sh_d;
  logic              rd_q, rd_d;
  logic              nack_q, nack_d;
  logic              scl_oe_q, scl_oe_d;
  logic              sda_oe_q, sda_oe_d;
  logic [31:0]       wt_q, wt_d;
  logic [7:0]        ib1_q, ib1_d;
  logic [7:0]        ib2_q, ib2_d;
  logic [7:0]        db_q [4];
  logic [7:0]        db_d [4];
  logic [7:0]        rdata_q, rdata_d;
  logic              tick;
  logic              txb;

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      sda_m_q <= 1'b1;
      sda_q   <= 1'b1;
    end else begin
      sda_m_q <= LINK.sda;
      sda_q   <= sda_m_q;
    end
  end

  function automatic logic [7:0] tx_byte(input logic [2:0] n);
    case (n)
      3'h0:    return {DEV_ADDR, rd_q};
      3'h1:    return ib1_q;
      default: return ib2_q;
    endcase
  endfunction : tx_byte

  assign tick = (qc_q == QW'(QTR - 1));
  assign txb  = !rd_q || (byte_q == 3'h0);

  always_comb begin
    st_d     = st_q;
    qc_d     = (st_q == adp_pkg::H_IDLE || tick) ? '0 : qc_q + 1'b1;
    ph_d     = ph_q;
    bit_d    = bit_q;
    byte_d   = byte_q;
    sh_d     = sh_q;
    rd_d     = rd_q;
    nack_d   = nack_q;
    scl_oe_d = scl_oe_q;
    sda_oe_d = sda_oe_q;
    wt_d     = (wt_q != 32'h0) ? wt_q - 32'h1 : wt_q;
    ib1_d    = ib1_q;
    ib2_d    = ib2_q;
    db_d     = db_q;
    rdata_d  = 8'h00;
    if (WR && st_q == adp_pkg::H_IDLE) begin
      // Orders and data are frozen while a transfer is running
      if (ADDR == adp_pkg::REG_IB1) ib1_d = WDATA;
      if (ADDR == adp_pkg::REG_IB2) ib2_d = WDATA;
      if (ADDR == adp_pkg::REG_CTRL && (WDATA[adp_pkg::CTRL_WR] || WDATA[adp_pkg::CTRL_RD])) begin
        rd_d   = !WDATA[adp_pkg::CTRL_WR];
        nack_d = 1'b0;
        st_d   = adp_pkg::H_WAIT;
      end
    end
    if (RD) begin
      case (ADDR)
        adp_pkg::REG_IB1:  rdata_d = ib1_q;
        adp_pkg::REG_IB2:  rdata_d = ib2_q;
        adp_pkg::REG_STAT: rdata_d = {5'h00, wt_q != 32'h0, nack_q, st_q != adp_pkg::H_IDLE};
        default: begin
          if (ADDR[3:2] == adp_pkg::REG_DB[3:2]) rdata_d = db_q[ADDR[1:0]];
        end
      endcase
    end
    case (st_q)
      adp_pkg::H_WAIT: begin
        // Reads are held back until the diagnostic settle time has run out
        if (!rd_q || wt_q == 32'h0) begin
          st_d   = adp_pkg::H_START;
          ph_d   = 2'h0;
          byte_d = 3'h0;
          bit_d  = 4'h0;
          sh_d   = tx_byte(3'h0);
        end
      end
      adp_pkg::H_START: begin
        if (tick) begin
          ph_d = ph_q + 2'h1;
          if (ph_q == 2'h0) sda_oe_d = 1'b1;
          if (ph_q == 2'h1) scl_oe_d = 1'b1;
          if (ph_q == 2'h3) begin
            st_d     = adp_pkg::H_BIT;
            sda_oe_d = !sh_q[7];
          end
        end
      end
      adp_pkg::H_BIT: begin
        if (tick) begin
          ph_d = ph_q + 2'h1;
          if (ph_q == 2'h0) scl_oe_d = 1'b0;
          if (ph_q == 2'h1) begin
            if (bit_q == adp_pkg::BIT_ACK) begin
              if (txb) nack_d = sda_q;
            end else if (!txb) begin
              sh_d = {sh_q[6:0], sda_q};
            end
          end
          if (ph_q == 2'h2) scl_oe_d = 1'b1;
          if (ph_q == 2'h3) begin
            if (bit_q != adp_pkg::BIT_ACK) begin
              bit_d = bit_q + 4'h1;
              if (txb) sh_d = {sh_q[6:0], 1'b0};
              if (bit_q == adp_pkg::BIT_ACK - 4'h1) begin
                sda_oe_d = !txb;
              end else begin
                sda_oe_d = txb && !sh_q[6];
              end
            end else begin
              bit_d  = 4'h0;
              byte_d = byte_q + 3'h1;
              if (!txb) db_d[byte_q[1:0] - 2'h1] = sh_q;
              if (nack_q || byte_q == (rd_q ? 3'h4 : 3'h2)) begin
                st_d     = adp_pkg::H_STOP;
                sda_oe_d = 1'b1;
              end else begin
                sh_d     = tx_byte(byte_q + 3'h1);
                sda_oe_d = !rd_q && !sh_d[7];
              end
            end
          end
        end
      end
      adp_pkg::H_STOP: begin
        if (tick) begin
          ph_d = ph_q + 2'h1;
          if (ph_q == 2'h0) scl_oe_d = 1'b0;
          if (ph_q == 2'h2) sda_oe_d = 1'b0;
          if (ph_q == 2'h3) begin
            st_d = adp_pkg::H_IDLE;
            if (!rd_q && !nack_q && (ib1_q[adp_pkg::IB1_DIAG] ||
                ((ib1_q & adp_pkg::OFFS_IB1_MASK) == adp_pkg::OFFS_IB1_MASK && ib2_q[adp_pkg::IB2_ON]))) begin
              wt_d = 32'(WAIT_CYC);
            end
          end
        end
      end
      default: begin
        scl_oe_d = 1'b0;
        sda_oe_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      st_q     <= adp_pkg::H_IDLE;
      qc_q     <= '0;
      ph_q     <= 2'h0;
      bit_q    <= 4'h0;
      byte_q   <= 3'h0;
      sh_q     <= 8'h00;
      rd_q     <= 1'b0;
      nack_q   <= 1'b0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      wt_q     <= 32'h0;
      ib1_q    <= adp_pkg::IB_RST;
      ib2_q    <= adp_pkg::IB_RST;
      db_q     <= '{default: 8'h00};
      rdata_q  <= 8'h00;
    end else begin
      st_q     <= st_d;
      qc_q     <= qc_d;
      ph_q     <= ph_d;
      bit_q    <= bit_d;
      byte_q   <= byte_d;
      sh_q     <= sh_d;
      rd_q     <= rd_d;
      nack_q   <= nack_d;
      scl_oe_q <= scl_oe_d;
      sda_oe_q <= sda_oe_d;
      wt_q     <= wt_d;
      ib1_q    <= ib1_d;
      ib2_q    <= ib2_d;
      db_q     <= db_d;
      rdata_q  <= rdata_d;
    end
  end

  assign LINK.scl_o    = 1'b0;
  assign LINK.scl_oe   = scl_oe_q;
  assign LINK.sda_h_o  = 1'b0;
  assign LINK.sda_h_oe = sda_oe_q;
  assign RDATA         = rdata_q;
endmodule : adp_host

// ==== testbench/adp_link_props.sv ====
`timescale 1ns/10ps
module adp_link_props #(
  parameter int QTR = 8
) (
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_h_o,
  input wire logic sda_h_oe,
  input wire logic sda_d_o,
  input wire logic sda_d_oe,
  input wire logic scl,
  input wire logic sda
);
  localparam int TMAX = 4 * QTR;
  logic [3:0] bitn_q;
  logic [3:0] bitn_d;
  logic       scl_q;
  logic       sda_q;

  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RESET);

  // Ninth rise of each byte is the ack slot
  always_comb begin
    bitn_d = bitn_q;
    if (scl && scl_q && sda_q && !sda) bitn_d = 4'h0;
    else if (scl && !scl_q) bitn_d = (bitn_q == 4'h8) ? 4'h0 : bitn_q + 4'h1;
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      bitn_q <= 4'h0;
      scl_q  <= 1'b1;
      sda_q  <= 1'b1;
    end else begin
      bitn_q <= bitn_d;
      scl_q  <= scl;
      sda_q  <= sda;
    end
  end

  ports_od_a: assert property (!scl_o && !sda_h_o && !sda_d_o)
    else $error("open-drain output driven high");
  rst_release_a: assert property (disable iff (1'b0) RESET |=> !scl_oe && !sda_h_oe && !sda_d_oe)
    else $error("bus not released after reset");
  dev_scl_low_a: assert property ($changed(sda_d_oe) |-> !scl)
    else $error("device moved SDA while SCL high");
  scl_low_hold_a: assert property ($rose(scl_oe) |=> scl_oe [*8])
    else $error("SCL low phase too short");
  scl_high_hold_a: assert property ($fell(scl_oe) |=> !scl_oe [*8])
    else $error("SCL high phase too short");
  start_form_a: assert property ($fell(sda) && scl |-> ##[1:TMAX] !scl)
    else $error("no clock after start");
  dev_hold_a: assert property ($rose(sda_d_oe) |=> sda_d_oe [*8])
    else $error("device bit too short");
  ack_low_a: assert property (scl && !scl_q && bitn_q == 4'h8 |-> !sda)
    else $error("byte not acknowledged");
endmodule : adp_link_props

// ==== testbench/test_amp_diag_i2c_command_port.sv ====
`timescale 1ns/10ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("[ERR] %0t got=%h exp=%h", $time, (got), (exp)); end end
module test_amp_diag_i2c_command_port;
  typedef struct packed {logic [7:0] val; logic [7:0] msk;} adp_note_s;
  localparam int unsigned QTR_T = 8;
  logic       sys_clk = 1'b0;
  logic       reset = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr_s = 1'b0;
  logic       rd_s = 1'b0;
  logic       rd_prev = 1'b0;
  logic [7:0] rdata;
  logic [3:0] open_load = 4'h0, offset_det = 4'h0, short_vcc = 4'h0, short_gnd = 4'h0;
  logic [3:0] short_load = 4'h0, cur_open = 4'h0;
  logic       turnon_done = 1'b0, therm_warn2 = 1'b0, therm_warn3 = 1'b0, ssr_mute = 1'b0;
  logic [7:0] first_ib, second_ib;
  logic       amp_on, diag_en, offset_en, diag_perm;
  int         n_mismatch = 0;
  int         check_count = 0;
  adp_note_s  notes[$];
  adp_note_s  note;

  adp_link_if link_if ();
  adp_host #(.QTR(QTR_T), .WAIT_CYC(50)) adp_host_inst (.SYS_CLK(sys_clk), .RESET(reset),
    .LINK(link_if.host), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s), .RDATA(rdata));
  adp_dev adp_dev_inst (.SYS_CLK(sys_clk), .RESET(reset), .LINK(link_if.dev), .OPEN_LOAD(open_load),
    .OFFSET_DET(offset_det), .SHORT_VCC(short_vcc), .SHORT_GND(short_gnd), .SHORT_LOAD(short_load),
    .CUR_OPEN(cur_open), .TURNON_DONE(turnon_done), .THERM_WARN2(therm_warn2), .THERM_WARN3(therm_warn3),
    .SSR_MUTE(ssr_mute), .FIRST_IB(first_ib), .SECOND_IB(second_ib), .AMP_ON(amp_on), .DIAG_EN(diag_en),
    .OFFSET_EN(offset_en), .DIAG_PERM(diag_perm));
  adp_link_props #(.QTR(QTR_T)) adp_link_props_inst (.SYS_CLK(sys_clk), .RESET(reset),
    .scl_o(link_if.scl_o), .scl_oe(link_if.scl_oe), .sda_h_o(link_if.sda_h_o), .sda_h_oe(link_if.sda_h_oe),
    .sda_d_o(link_if.sda_d_o), .sda_d_oe(link_if.sda_d_oe), .scl(link_if.scl), .sda(link_if.sda));

  always #2 sys_clk = ~sys_clk;

  // Read data stands only in the cycle after the strobe
  always @(posedge sys_clk) begin
    rd_prev <= rd_s;
    if (rd_prev) begin
      note = notes.pop_front();
      `CHK(rdata & note.msk, note.val & note.msk)
    end
  end

  task automatic wrap_up();
    if (n_mismatch == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up

  task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge sys_clk);
    wr_s  <= 1'b0;
  endtask : bus_wr

  task automatic bus_rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge sys_clk);
    addr <= a;
    rd_s <= 1'b1;
    notes.push_back('{val: e, msk: m});
    @(posedge sys_clk);
    rd_s <= 1'b0;
  endtask : bus_rd

  task automatic wait_idle();
    int n = 0;
    do begin
      bus_rd(adp_pkg::REG_STAT, 8'h00, 8'h00);
      #1;
      n++;
    end while (rdata[0] !== 1'b0 && n < 4000);
    if (n >= 4000) begin
      n_mismatch++;
      wrap_up();
    end
    `CHK(rdata[1], 1'b0)
    @(posedge sys_clk);
  endtask : wait_idle

  task automatic xfer(input logic [7:0] b1, input logic [7:0] b2);
    bus_wr(adp_pkg::REG_IB1, b1);
    bus_wr(adp_pkg::REG_IB2, b2);
    bus_wr(adp_pkg::REG_CTRL, 8'h01);
    wait_idle();
    `CHK(first_ib, b1)
    `CHK(second_ib, b2)
  endtask : xfer

  task automatic read_all();
    bus_wr(adp_pkg::REG_CTRL, 8'h02);
    wait_idle();
  endtask : read_all

  // Rear right only: k = {short load, short gnd, short vcc, offset, open load}
  task automatic pulse(input logic [4:0] k);
    @(posedge sys_clk);
    open_load  <= {k[0], 3'h0};
    offset_det <= {k[1], 3'h0};
    short_vcc  <= {k[2], 3'h0};
    short_gnd  <= {k[3], 3'h0};
    short_load <= {k[4], 3'h0};
    @(posedge sys_clk);
    {open_load, offset_det, short_vcc, short_gnd, short_load} <= 20'h0;
  endtask : pulse

  initial begin
    logic [31:0] r;
    logic [7:0]  b1;
    logic [7:0]  b2;
    r = $urandom(32'h4554);
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (4) @(posedge sys_clk);
    bus_rd(4'h8, 8'h00, 8'hff);
    xfer(8'h40, r[7:0] | 8'h10);
    `CHK(diag_en, 1'b1)
    `CHK(diag_perm, 1'b0)
    r = $urandom;
    cur_open    <= r[7:4];
    therm_warn2 <= r[8];
    therm_warn3 <= r[9];
    ssr_mute    <= r[10];
    pulse(r[15:11]);
    read_all();
    bus_rd(adp_pkg::REG_DB + 4'h3, {r[8], r[9], r[7], 1'b0, r[15], r[11], r[13], r[14]}, 8'hff);
    bus_rd(adp_pkg::REG_DB + 4'h2, 8'hc0, 8'hc0);
    bus_rd(adp_pkg::REG_DB + 4'h1, {1'b0, r[10], 6'h0}, 8'hc0);
    bus_rd(adp_pkg::REG_DB, 8'h00, 8'hc0);
    // Flags drop after a whole four-byte read or a first order written with bit6 set
    read_all();
    bus_rd(adp_pkg::REG_DB + 4'h3, {r[8], r[9], r[7], 5'h0}, 8'hff);
    for (int i = 0; i < 2; i++) begin
      r  = $urandom;
      b1 = (i == 0) ? {r[0], 7'h0} : (r[7:0] & 8'hb9);
      b2 = (i == 0) ? (r[15:8] | 8'h13) : (r[15:8] & 8'hef);
      xfer(b1, b2);
      `CHK(amp_on, (i == 0))
    end
    r = $urandom;
    xfer((r[7:0] | 8'h26) & 8'hbf, r[15:8] | 8'h10);
    `CHK(offset_en, 1'b1)
    pulse(5'h02);
    read_all();
    bus_rd(adp_pkg::REG_DB + 4'h1, 8'h80, 8'h80);
    bus_rd(adp_pkg::REG_DB + 4'h3, 8'h04, 8'h1f);
    `CHK(offset_en, 1'b0)
    @(posedge sys_clk);
    turnon_done <= 1'b1;
    @(posedge sys_clk);
    turnon_done <= 1'b0;
    pulse(5'h02);
    `CHK(diag_perm, 1'b1)
    read_all();
    bus_rd(adp_pkg::REG_DB + 4'h3, 8'h14, 8'h1f);
    repeat (4) @(posedge sys_clk);
    wrap_up();
  end
endmodule : test_amp_diag_i2c_command_port
